// >>> inc/nvm_defs.svh
// offsets, field positions, reset values and timing counts of the nvm access block
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// ==========================================================================
// register byte offsets
`define NVM_OFS_ADDRESS 8'h00
`define NVM_OFS_DATA 8'h04
`define NVM_OFS_KEY 8'h08
`define NVM_OFS_CONTROL 8'h0C
`define NVM_OFS_IRQ_STATUS 8'h10
`define NVM_OFS_IRQ_MASK 8'h14

// ==========================================================================
// nvm_control_reg bit positions
`define NVM_CTL_PGM 7
`define NVM_CTL_CFG 6
`define NVM_CTL_ROW 4
`define NVM_CTL_ABORT 3
`define NVM_CTL_PERMIT 2
`define NVM_CTL_WSTART 1
`define NVM_CTL_RSTART 0

// ==========================================================================
// interrupt status bit positions
`define NVM_IRQ_DONE 0
`define NVM_IRQ_REFUSED 1
`define NVM_IRQ_BITS 2

// ==========================================================================
// reset values and key values
`define NVM_ADDR_RESET 8'h00
`define NVM_DATA_RESET 8'h00
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA

// ==========================================================================
// bus answers
`define NVM_RESP_OKAY 2'h0
`define NVM_RESP_SLVERR 2'h2

// ==========================================================================
// timing: self-timed write length
`define NVM_CLK_PERIOD_NS 5
`define NVM_WRITE_TIME_NS 4000000
`define NVM_WRITE_CYCLES (`NVM_WRITE_TIME_NS / `NVM_CLK_PERIOD_NS)

`endif

// >>> inc/nvm_pkg.sv
// types shared by the nvm access block
package nvm_pkg;

   // ==========================================================================
   // unlock key tracker states
   typedef enum logic [1:0]
   {
      UNLOCK_IDLE,
      UNLOCK_GOT_FIRST,
      UNLOCK_ARMED
   } unlock_state_t;

endpackage : nvm_pkg

// >>> core/nvm_byte_array.sv
// byte-wide storage array with one write port and two read ports
`timescale 1ns/100ps

module nvm_byte_array
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
)
(
   // clock
   input wire logic aclk,
   // write port
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [DATA_W-1:0] wdata,
   // read ports
   input wire logic [ADDR_W-1:0] raddr_a,
   input wire logic [ADDR_W-1:0] raddr_b,
   output logic [DATA_W-1:0] rdata_a,
   output logic [DATA_W-1:0] rdata_b
);

   // ==========================================================================
   // storage: no reset, contents survive like the real array
   logic [DATA_W-1:0] mem_q [1<<ADDR_W];
   logic [DATA_W-1:0] mem_d [1<<ADDR_W];

   // one byte changes per write
   always_comb
   begin
      mem_d = mem_q;
      if (we)
      begin
         mem_d[waddr] = wdata;
      end
   end

   // register the array
   always_ff @(posedge aclk)
   begin
      mem_q <= mem_d;
   end

   // read ports are plain muxes
   assign rdata_a = mem_q[raddr_a];
   assign rdata_b = mem_q[raddr_b];

endmodule : nvm_byte_array

// >>> core/nvm_access_ctrl.sv
// data nvm access controller with axi4-lite registers and programmer port
`timescale 1ns/100ps
`include "nvm_defs.svh"

// Operation
// - programmer access refused under code protect
// - cpu access ignores code protect
// - one address selects one byte
// - address register resets to zero
// - data register resets to zero
// - control reset: por clears, others keep three
// - write start stays set until write ends
// - write start ignored without write permit
// - one-cycle read loads data, clears start
// - non-power-on reset during write sets abort flag
// - key port reads as zero
module nvm_access_ctrl
#(
   parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // reset cause and configuration setting
   input wire logic por_reset,
   input wire logic code_protect,
   // axi4-lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // external programming port
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic [7:0] ext_addr,
   input wire logic [7:0] ext_wdata,
   output logic ext_ack,
   output logic ext_refused,
   output logic [7:0] ext_rdata,
   // interrupt
   output logic irq
);

   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

   // ==========================================================================
   // state
   logic aw_held_q, aw_held_d;          // write address taken
   logic w_held_q, w_held_d;            // write data taken
   logic [7:0] aw_ofs_q, aw_ofs_d;      // taken write offset
   logic [7:0] w_byte_q, w_byte_d;      // taken write byte
   logic w_lane_q, w_lane_d;            // low byte lane enabled
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [7:0] nvm_address_q, nvm_address_d;
   logic [7:0] nvm_data_q, nvm_data_d;
   logic pgm_sel_q, pgm_sel_d;          // program_space_select
   logic cfg_sel_q, cfg_sel_d;          // config_space_select
   logic row_erase_q, row_erase_d;      // stored only, no flash here
   logic write_abort_q, write_abort_d;  // write_abort_flag
   logic write_permit_q, write_permit_d;
   logic write_start_q, write_start_d;
   logic read_start_q, read_start_d;
   logic [CNT_W-1:0] wcnt_q, wcnt_d;    // cycles left in self-timed write
   nvm_pkg::unlock_state_t unlock_q, unlock_d;
   logic [`NVM_IRQ_BITS-1:0] irq_status_q, irq_status_d;
   logic [`NVM_IRQ_BITS-1:0] irq_mask_q, irq_mask_d;
   logic irq_q, irq_d;
   logic ext_ack_q, ext_ack_d;
   logic ext_refused_q, ext_refused_d;
   logic [7:0] ext_rdata_q, ext_rdata_d;

   // ==========================================================================
   // decode helpers
   logic wr_fire;       // register write performed this cycle
   logic reg_wr;        // ...with low lane enabled
   logic wr_mapped;
   logic [7:0] ctl_view;
   logic [7:0] mem_rd_cpu;
   logic [7:0] mem_rd_ext;
   logic mem_we;
   logic [7:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic ext_go;        // programmer request taken
   logic cpu_commit;    // self-timed write finishes
   logic read_go;       // software set read_start

   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign reg_wr = wr_fire && w_lane_q;
   assign wr_mapped = aw_ofs_q <= `NVM_OFS_IRQ_MASK && aw_ofs_q[1:0] == 2'h0;
   assign ctl_view = {pgm_sel_q, cfg_sel_q, 1'b0, row_erase_q,
                      write_abort_q, write_permit_q, write_start_q, read_start_q};
   assign cpu_commit = write_start_q && wcnt_q == '0;
   // programmer waits while a cpu write runs; the array has one write port
   assign ext_go = ext_req && !ext_ack_q && !write_start_q;
   assign read_go = reg_wr && aw_ofs_q == `NVM_OFS_CONTROL && !write_start_q
                    && w_byte_q[`NVM_CTL_RSTART]
                    && !w_byte_q[`NVM_CTL_PGM] && !w_byte_q[`NVM_CTL_CFG];

   // ==========================================================================
   // array write port: cpu commit or programmer write, never both
   assign mem_we = cpu_commit || (ext_go && ext_write && !code_protect);
   assign mem_waddr = cpu_commit ? nvm_address_q : ext_addr;
   assign mem_wdata = cpu_commit ? nvm_data_q : ext_wdata;

   // byte array, one byte per address
   nvm_byte_array #(.ADDR_W(8), .DATA_W(8)) u_array
   (
      .aclk(aclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr_a(nvm_address_q),
      .raddr_b(ext_addr),
      .rdata_a(mem_rd_cpu),
      .rdata_b(mem_rd_ext)
   );

   // ==========================================================================
   // axi write channels: address and data taken in either order
   always_comb
   begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      aw_ofs_d = aw_ofs_q;
      w_byte_d = w_byte_q;
      w_lane_d = w_lane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (awvalid && !aw_held_q)
      begin
         aw_held_d = 1'b1;
         aw_ofs_d = awaddr[7:0];
      end
      if (wvalid && !w_held_q)
      begin
         w_held_d = 1'b1;
         w_byte_d = wdata[7:0];
         w_lane_d = wstrb[0];
      end
      if (wr_fire)
      begin
         // both halves present: act and answer
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_mapped ? `NVM_RESP_OKAY : `NVM_RESP_SLVERR;
      end
      else if (bvalid_q && bready)
      begin
         bvalid_d = 1'b0;
      end
   end

   // ==========================================================================
   // axi read channel: one read at a time, answer the edge after taking
   always_comb
   begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (arvalid && arready_q)
      begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = `NVM_RESP_OKAY;
         case (araddr[7:0])
            `NVM_OFS_ADDRESS: rdata_d = {24'h00_0000, nvm_address_q};
            `NVM_OFS_DATA: rdata_d = {24'h00_0000, nvm_data_q};
            `NVM_OFS_KEY: rdata_d = 32'h0000_0000;
            `NVM_OFS_CONTROL: rdata_d = {24'h00_0000, ctl_view};
            `NVM_OFS_IRQ_STATUS: rdata_d = {30'h0000_0000, irq_status_q};
            `NVM_OFS_IRQ_MASK: rdata_d = {30'h0000_0000, irq_mask_q};
            default:
            begin
               // unmapped: error answer, zero data
               rdata_d = 32'h0000_0000;
               rresp_d = `NVM_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && rready)
      begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end

   // ==========================================================================
   // unlock tracker: 55h then AAh arms one write start
   always_comb
   begin
      unlock_d = unlock_q;
      if (reg_wr && aw_ofs_q == `NVM_OFS_KEY)
      begin
         case (unlock_q)
            nvm_pkg::UNLOCK_GOT_FIRST:
               unlock_d = (w_byte_q == `NVM_KEY_SECOND) ? nvm_pkg::UNLOCK_ARMED :
                          (w_byte_q == `NVM_KEY_FIRST) ? nvm_pkg::UNLOCK_GOT_FIRST :
                          nvm_pkg::UNLOCK_IDLE;
            default:
               unlock_d = (w_byte_q == `NVM_KEY_FIRST) ? nvm_pkg::UNLOCK_GOT_FIRST :
                          nvm_pkg::UNLOCK_IDLE;
         endcase
      end
      else if (wr_fire)
      begin
         // any other write consumes or breaks the sequence
         unlock_d = nvm_pkg::UNLOCK_IDLE;
      end
   end

   // ==========================================================================
   // address, data, control and the self-timed write
   always_comb
   begin
      nvm_address_d = nvm_address_q;
      nvm_data_d = nvm_data_q;
      pgm_sel_d = pgm_sel_q;
      cfg_sel_d = cfg_sel_q;
      row_erase_d = row_erase_q;
      write_abort_d = write_abort_q;
      write_permit_d = write_permit_q;
      write_start_d = write_start_q;
      read_start_d = 1'b0;
      wcnt_d = wcnt_q;
      // a read completes one cycle after it is started
      if (read_start_q)
      begin
         nvm_data_d = mem_rd_cpu;
      end
      // cpu access never looks at code_protect
      if (reg_wr && !write_start_q)
      begin
         case (aw_ofs_q)
            `NVM_OFS_ADDRESS: nvm_address_d = w_byte_q;
            `NVM_OFS_DATA: nvm_data_d = w_byte_q;
            `NVM_OFS_CONTROL:
            begin
               pgm_sel_d = w_byte_q[`NVM_CTL_PGM];
               cfg_sel_d = w_byte_q[`NVM_CTL_CFG];
               row_erase_d = w_byte_q[`NVM_CTL_ROW];
               write_abort_d = w_byte_q[`NVM_CTL_ABORT];
               write_permit_d = w_byte_q[`NVM_CTL_PERMIT];
               read_start_d = read_go;
               // permit must already be set; starts are set-only
               if (w_byte_q[`NVM_CTL_WSTART] && write_permit_q
                   && unlock_q == nvm_pkg::UNLOCK_ARMED
                   && !w_byte_q[`NVM_CTL_PGM] && !w_byte_q[`NVM_CTL_CFG])
               begin
                  write_start_d = 1'b1;
                  wcnt_d = CNT_LAST;
               end
            end
            default: ;
         endcase
      end
      else if (reg_wr && aw_ofs_q == `NVM_OFS_CONTROL)
      begin
         // during a write only write_permit may change
         write_permit_d = w_byte_q[`NVM_CTL_PERMIT];
      end
      // write_start holds until the timer runs out
      if (write_start_q)
      begin
         if (cpu_commit)
         begin
            write_start_d = 1'b0;
         end
         else
         begin
            wcnt_d = wcnt_q - CNT_W'(1);
         end
      end
   end

   // ==========================================================================
   // interrupt status (w1c, set wins), mask, and programmer answer
   always_comb
   begin
      irq_status_d = irq_status_q;
      irq_mask_d = irq_mask_q;
      if (reg_wr && aw_ofs_q == `NVM_OFS_IRQ_STATUS)
      begin
         irq_status_d = irq_status_q & ~w_byte_q[`NVM_IRQ_BITS-1:0];
      end
      if (reg_wr && aw_ofs_q == `NVM_OFS_IRQ_MASK)
      begin
         irq_mask_d = w_byte_q[`NVM_IRQ_BITS-1:0];
      end
      if (cpu_commit)
      begin
         irq_status_d[`NVM_IRQ_DONE] = 1'b1;
      end
      if (ext_go && code_protect)
      begin
         irq_status_d[`NVM_IRQ_REFUSED] = 1'b1;
      end
      irq_d = |(irq_status_d & irq_mask_d);
      // programmer port: one-cycle ack, zero data when refused
      ext_ack_d = ext_go;
      ext_refused_d = ext_go && code_protect;
      ext_rdata_d = ext_rdata_q;
      if (ext_go)
      begin
         ext_rdata_d = (code_protect || ext_write) ? 8'h00 : mem_rd_ext;
      end
   end

   // ==========================================================================
   // registers; sync reset, control bits depend on the reset cause
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_ofs_q <= 8'h00;
         w_byte_q <= 8'h00;
         w_lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `NVM_RESP_OKAY;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `NVM_RESP_OKAY;
         nvm_address_q <= `NVM_ADDR_RESET;
         nvm_data_q <= `NVM_DATA_RESET;
         // unknown on power-on taken as zero; kept on other resets, abort also set by a running write
         pgm_sel_q <= por_reset ? 1'b0 : pgm_sel_q;
         cfg_sel_q <= por_reset ? 1'b0 : cfg_sel_q;
         write_abort_q <= por_reset ? 1'b0 : (write_abort_q | write_start_q);
         row_erase_q <= 1'b0;
         write_permit_q <= 1'b0;
         write_start_q <= 1'b0;
         read_start_q <= 1'b0;
         wcnt_q <= '0;
         unlock_q <= nvm_pkg::UNLOCK_IDLE;
         irq_status_q <= '0;
         irq_mask_q <= '0;
         irq_q <= 1'b0;
         ext_ack_q <= 1'b0;
         ext_refused_q <= 1'b0;
         ext_rdata_q <= 8'h00;
      end
      else
      begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         aw_ofs_q <= aw_ofs_d;
         w_byte_q <= w_byte_d;
         w_lane_q <= w_lane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         nvm_address_q <= nvm_address_d;
         nvm_data_q <= nvm_data_d;
         pgm_sel_q <= pgm_sel_d;
         cfg_sel_q <= cfg_sel_d;
         write_abort_q <= write_abort_d;
         row_erase_q <= row_erase_d;
         write_permit_q <= write_permit_d;
         write_start_q <= write_start_d;
         read_start_q <= read_start_d;
         wcnt_q <= wcnt_d;
         unlock_q <= unlock_d;
         irq_status_q <= irq_status_d;
         irq_mask_q <= irq_mask_d;
         irq_q <= irq_d;
         ext_ack_q <= ext_ack_d;
         ext_refused_q <= ext_refused_d;
         ext_rdata_q <= ext_rdata_d;
      end
   end

   // ==========================================================================
   // outputs straight from flops
   assign awready = !aw_held_q;
   assign wready = !w_held_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign ext_ack = ext_ack_q;
   assign ext_refused = ext_refused_q;
   assign ext_rdata = ext_rdata_q;
   assign irq = irq_q;

   // ==========================================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   prot_refuse_a: assert property (ext_go && code_protect |=> ext_refused_q
      && ext_ack_q && ext_rdata_q == 8'h00)
      else $error("protected programmer access not refused");
   cpu_prot_a: assert property (read_go && code_protect |=> ##1
      nvm_data_q == $past(mem_rd_cpu))
      else $error("cpu read blocked by code protect");
   reset_zero_a: assert property ($rose(aresetn) |-> nvm_address_q == 8'h00
      && nvm_data_q == 8'h00 && !write_start_q)
      else $error("address or data not zero after reset");
   write_hold_a: assert property (write_start_q && !cpu_commit |=> write_start_q)
      else $error("write start dropped early");
   write_end_a: assert property (cpu_commit |=> !write_start_q
      && irq_status_q[`NVM_IRQ_DONE])
      else $error("write end not flagged");
   permit_gate_a: assert property ($rose(write_start_q) |-> $past(write_permit_q))
      else $error("write began without permit");
   unlock_need_a: assert property ($rose(write_start_q) |->
      $past(unlock_q) == nvm_pkg::UNLOCK_ARMED)
      else $error("write began without unlock");
   read_cycle_a: assert property (read_go |=> read_start_q ##1
      (!read_start_q && nvm_data_q == $past(mem_rd_cpu)))
      else $error("read did not finish in one cycle");
   abort_set_a: assert property ($rose(aresetn) && !$past(por_reset)
      && $past(write_start_q, 2) |-> write_abort_q)
      else $error("reset during write left abort clear");
   key_zero_a: assert property (arvalid && arready_q && araddr[7:0] == `NVM_OFS_KEY
      |=> rvalid_q && rdata_q == 32'h0000_0000)
      else $error("key port read not zero");

   write_done_c: cover property (cpu_commit);
   ext_refuse_c: cover property (ext_go && code_protect);
   cpu_read_c: cover property (read_go ##4 rvalid_q);

endmodule : nvm_access_ctrl

// >>> dv/test_nvm_access_ctrl.sv
// self-checking bench for the nvm access controller
`timescale 1ns/100ps
`include "nvm_defs.svh"

module test_nvm_access_ctrl;
   // ==========================================================
   // ports, counters and the byte array model
   logic aclk, aresetn, por_reset, code_protect;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, ext_req, ext_write, ext_ack, ext_refused, irq;
   logic [31:0] awaddr, wdata, araddr, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:0] ext_addr, ext_wdata, ext_rdata, a, d, ed;
   logic ef;
   int failures, n_compared, t;
   logic [7:0] mem_m [256]; // expected array contents

   nvm_access_ctrl #(.WRITE_CYCLES(8)) nvm_access_ctrl_inst (.aclk, .aresetn, .por_reset,
      .code_protect, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .ext_req, .ext_write, .ext_addr, .ext_wdata, .ext_ack, .ext_refused, .ext_rdata, .irq);

   // ==========================================================
   // clock and watchdog
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   initial
   begin
      #200000;
      failures++;
      stop_test();
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // axi write: hold each channel until its own ready edge
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      bit dn;
      dn = 0;
      @(posedge aclk);
      awaddr <= {24'h00_0000, ad};
      wdata <= {24'h00_0000, dt};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 100 && !dn; i++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            dn = 1;
         end
      end
      if (!dn) failures++;
   endtask : wr
   task automatic rd(input logic [7:0] ad);
      bit dn;
      dn = 0;
      @(posedge aclk);
      araddr <= {24'h00_0000, ad};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 100 && !dn; i++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            v = rdata;
            r = rresp;
            rready <= 1'b0;
            dn = 1;
         end
      end
      if (!dn) failures++;
   endtask : rd
   task automatic rc(input logic [7:0] ad, input logic [7:0] e);
      rd(ad);
      chk(v, {24'h00_0000, e});
   endtask : rc
   // unlock sequence with k2 written between the keys unless it is AAh, then start
   task automatic cw(input logic [7:0] ad, input logic [7:0] dt, input logic [7:0] k2);
      wr(`NVM_OFS_ADDRESS, ad);
      wr(`NVM_OFS_DATA, dt);
      wr(`NVM_OFS_CONTROL, 8'h04);
      wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
      if (k2 != `NVM_KEY_SECOND) wr(`NVM_OFS_KEY, k2);
      wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
      wr(`NVM_OFS_CONTROL, 8'h06);
   endtask : cw
   task automatic cread(input logic [7:0] ad);
      wr(`NVM_OFS_ADDRESS, ad);
      wr(`NVM_OFS_CONTROL, 8'h01);
      rc(`NVM_OFS_DATA, mem_m[ad]);
   endtask : cread
   // programmer request held until ack
   task automatic ext(input logic w, input logic [7:0] ad, input logic [7:0] dt);
      @(posedge aclk);
      ext_req <= 1'b1;
      ext_write <= w;
      ext_addr <= ad;
      ext_wdata <= dt;
      t = 0;
      do
      begin
         @(posedge aclk);
         t++;
      end
      while (!ext_ack && t < 100);
      if (!ext_ack) failures++;
      ext_req <= 1'b0;
      ed = ext_rdata;
      ef = ext_refused;
   endtask : ext
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   // hold reset for two edges; p picks power-on or other reset
   task automatic rst(input logic p);
      aresetn <= 1'b0;
      por_reset <= p;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : rst

   // ==========================================================
   // main sequence
   initial
   begin
      {aresetn, code_protect, awvalid, wvalid, bready, arvalid, rready, ext_req} = '0;
      {awaddr, wdata, araddr, ext_write, ext_addr, ext_wdata} = '0;
      por_reset = 1'b1;
      wstrb = 4'hF;
      void'($urandom(81));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`NVM_OFS_ADDRESS, 8'h00);
      rc(`NVM_OFS_DATA, 8'h00);
      rc(`NVM_OFS_CONTROL, 8'h00);
      rc(`NVM_OFS_KEY, 8'h00);
      rd(8'h40);
      chk(32'(r), 32'(`NVM_RESP_SLVERR));
      wr(8'h40, 8'h00);
      chk(32'(r), 32'(`NVM_RESP_SLVERR));
      // start without permit is dropped
      wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
      wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
      wr(`NVM_OFS_CONTROL, 8'h02);
      rc(`NVM_OFS_CONTROL, 8'h00);
      // random byte writes, masked and unmasked interrupt
      for (int i = 0; i < 4; i++)
      begin
         a = 8'($urandom);
         d = 8'($urandom);
         wr(`NVM_OFS_IRQ_MASK, 8'(i % 2));
         cw(a, d, `NVM_KEY_SECOND);
         mem_m[a] = d;
         rc(`NVM_OFS_CONTROL, 8'h06);
         t = 0;
         do
         begin
            rd(`NVM_OFS_CONTROL);
            t++;
         end
         while (v[1] && t < 50);
         chk(v, 32'h0000_0004);
         repeat (2) @(posedge aclk);
         chk(32'(irq), 32'(i % 2));
         rc(`NVM_OFS_IRQ_STATUS, 8'h01);
         wr(`NVM_OFS_IRQ_STATUS, 8'h01);
         repeat (2) @(posedge aclk);
         chk(32'(irq), 32'h0000_0000);
         cread(a);
      end
      // a stray key value breaks the unlock
      cw(a, ~d, 8'h00);
      rc(`NVM_OFS_CONTROL, 8'h04);
      cread(a);
      // programmer port open, then protected
      ext(1'b1, ~a, d);
      mem_m[~a] = d;
      cread(~a);
      ext(1'b0, ~a, 8'h00);
      chk(32'({ef, ed}), 32'({1'b0, d}));
      code_protect <= 1'b1;
      ext(1'b0, a, 8'h00);
      chk(32'({ef, ed}), 32'({1'b1, 8'h00}));
      ext(1'b1, a, ~d);
      cread(a);
      rc(`NVM_OFS_IRQ_STATUS, 8'h02);
      cw(a, ~d, `NVM_KEY_SECOND);
      mem_m[a] = ~d;
      repeat (20) @(posedge aclk);
      cread(a);
      // refresh: rewrite a location with its modelled byte, then read it back
      cw(a, mem_m[a], `NVM_KEY_SECOND);
      repeat (20) @(posedge aclk);
      cread(a);
      // reset in mid-write, select bits kept, then power-on reset
      cw(a, d, `NVM_KEY_SECOND);
      rst(1'b0);
      rc(`NVM_OFS_CONTROL, 8'h08);
      rc(`NVM_OFS_ADDRESS, 8'h00);
      rc(`NVM_OFS_DATA, 8'h00);
      wr(`NVM_OFS_CONTROL, 8'hC0);
      rst(1'b0);
      rc(`NVM_OFS_CONTROL, 8'hC0);
      rst(1'b1);
      rc(`NVM_OFS_CONTROL, 8'h00);
      stop_test();
   end
endmodule : test_nvm_access_ctrl
